// ===== hw/pcs_sequencer.sv
// program counter sequencer: counter, page bits, file registers, cycle costs
// assumes the decoder holds a request until o_ready and the irq line is on i_clk
//
// Function
// RQ1: counter of 11 bits for 2,048 words
// RQ2: low counter byte is file register 02h
// RQ3: advance whole counter by one per instruction
// RQ4: reset loads highest program address
// RQ5: taken interrupt loads address zero
// RQ6: taken skip adds two, cancels next instruction
// RQ7: taken skip costs one extra clock
// RQ8: jump uses nine opcode bits plus page bits
// RQ9: page bits sit in status bits 7:5
// RQ10: page load writes only page bits, one clock
// RQ11: jump costs two compatible, three turbo clocks
// RQ12: low byte writes keep upper counter bits
// RQ13: low byte jump costs four compatible, three turbo
// RQ14: bit and arithmetic ops rewrite whole register
// RQ15: port write stores register, read returns pins
// RQ16: software avoids back-to-back port rewrites
// RQ17: reloads of the counter flush the pipeline
// RQ18: sequential increment wraps modulo memory size
module pcs_sequencer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // clocking mode strap, 1 selects turbo
  input wire logic i_turbo,
  // interrupt request from the core
  input wire logic i_irq,
  // decoder request
  input wire logic i_req_valid,
  input wire pcs_pkg::pcs_req_type i_req,
  // port pins
  input wire logic [7:0] i_port_pins,
  // fetch side
  output logic [pcs_pkg::PC_W-1:0] o_fetch_addr,
  output logic o_ready,
  output logic o_flush,
  // register side
  output logic [7:0] o_fr_rdata,
  output logic [7:0] o_status,
  output logic [7:0] o_port_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [pcs_pkg::PC_W-1:0] pc_reg, pc_next;
  logic [7:0] status_reg, status_next;
  logic [7:0] port_reg, port_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [2:0] cnt_reg, cnt_next;
  logic ready_reg, ready_next;
  logic flush_reg, flush_next;
  logic turbo_meta_reg, turbo_sync_reg;
  logic [7:0] pins_meta_reg, pins_sync_reg;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic irq_take;
  wire logic accept;
  wire logic sel_pc;
  wire logic sel_st;
  wire logic sel_port;
  wire logic [7:0] bit_mask;
  wire logic [7:0] fr_old;
  wire logic [7:0] fr_new;
  wire logic fr_writes;
  wire logic skip_true;
  wire logic is_jump;
  wire logic is_page;
  wire logic pc_write;
  wire logic [pcs_pkg::PC_W-1:0] pc_plus1;
  wire logic [pcs_pkg::PC_W-1:0] pc_plus2;
  wire logic [pcs_pkg::PC_W-1:0] jump_target;
  wire logic [2:0] cost;
  wire logic [2:0] seq_cost;

  // request acceptance; an interrupt wins over a waiting request
  assign irq_take = ready_reg && i_irq; // RQ5
  assign accept = ready_reg && i_req_valid && !i_irq;
  assign is_jump = accept && (i_req.op == pcs_pkg::OP_JUMP);
  assign is_page = accept && (i_req.op == pcs_pkg::OP_PAGE);

  // file register select and whole-register read
  assign sel_pc = (i_req.fr_addr == pcs_pkg::ADDR_PC_LOW); // RQ2
  assign sel_st = (i_req.fr_addr == pcs_pkg::ADDR_STATUS);
  assign sel_port = (i_req.fr_addr == pcs_pkg::ADDR_PORT);
  assign bit_mask = 8'h01 << i_req.bit_sel;
  assign fr_old = sel_pc ? pc_plus1[7:0] :
                  sel_st ? status_reg :
                  sel_port ? pins_sync_reg : 8'h00; // RQ15

  // read, modify, write back the full byte
  assign fr_new = (i_req.fn == pcs_pkg::FR_MOV) ? i_req.operand :
                  (i_req.fn == pcs_pkg::FR_ADD) ? fr_old + i_req.operand :
                  (i_req.fn == pcs_pkg::FR_SETB) ? (fr_old | bit_mask) :
                  (i_req.fn == pcs_pkg::FR_CLRB) ? (fr_old & ~bit_mask) :
                  (i_req.fn == pcs_pkg::FR_DEC) ? fr_old - 8'h01 : fr_old; // RQ14
  assign fr_writes = accept && (i_req.op == pcs_pkg::OP_FILE) &&
                     (i_req.fn != pcs_pkg::FR_READ);
  assign pc_write = fr_writes && sel_pc;

  // skip test on the addressed bit
  assign skip_true = accept && (i_req.op == pcs_pkg::OP_SKIP) &&
                     ((fr_old & bit_mask) != 8'h00);

  // counter arithmetic, wrapping at the memory size; top page bit unused at 11 bits
  assign pc_plus1 = pc_reg + pcs_pkg::PC_ONE; // RQ3 RQ18
  assign pc_plus2 = pc_reg + pcs_pkg::PC_TWO; // RQ6
  assign jump_target = {status_reg[pcs_pkg::PAGE_MSB-1:pcs_pkg::PAGE_LSB],
                        i_req.jaddr}; // RQ8 RQ9

  // next counter value, highest priority first
  assign pc_next = irq_take ? pcs_pkg::PC_INT : // RQ5
                   !accept ? pc_reg :
                   is_jump ? jump_target : // RQ8
                   pc_write ? {pc_plus1[pcs_pkg::PC_W-1:8], fr_new} : // RQ12
                   skip_true ? pc_plus2 : pc_plus1; // RQ6 RQ3

  // status: page load touches only the page field
  assign status_next = is_page ?
                       {i_req.page, status_reg[pcs_pkg::PAGE_LSB-1:0]} : // RQ10
                       (fr_writes && sel_st) ? fr_new : status_reg; // RQ14

  // port writes land in the data register only
  assign port_next = (fr_writes && sel_port) ? fr_new : port_reg; // RQ15
  assign rdata_next = (accept && (i_req.op == pcs_pkg::OP_FILE)) ? fr_old : rdata_reg;

  // cycle cost of the accepted operation
  assign seq_cost = turbo_sync_reg ? pcs_pkg::COST_SEQ_TURBO : pcs_pkg::COST_SEQ_COMPAT;
  assign cost = irq_take ? pcs_pkg::COST_INT :
                is_jump ? (turbo_sync_reg ? pcs_pkg::COST_JMP_TURBO :
                           pcs_pkg::COST_JMP_COMPAT) : // RQ11
                pc_write ? (turbo_sync_reg ? pcs_pkg::COST_PCW_TURBO :
                            pcs_pkg::COST_PCW_COMPAT) : // RQ13
                is_page ? pcs_pkg::COST_PAGE : // RQ10
                skip_true ? seq_cost + pcs_pkg::COST_SKIP_EXTRA : seq_cost; // RQ7

  // busy counter and ready
  assign cnt_next = (irq_take || accept) ? cost - 3'h1 :
                    (cnt_reg != 3'h0) ? cnt_reg - 3'h1 : 3'h0;
  assign ready_next = (cnt_next == 3'h0);

  // discard fetched work on any reload or cancelled instruction
  assign flush_next = irq_take || is_jump || pc_write || skip_true; // RQ17 RQ6

  // ----------------------------------------------------------------
  // synchronisers for the strap and the pins
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      turbo_meta_reg <= 1'b0;
      turbo_sync_reg <= 1'b0;
      pins_meta_reg <= 8'h00;
      pins_sync_reg <= 8'h00;
    end else begin
      turbo_meta_reg <= i_turbo;
      turbo_sync_reg <= turbo_meta_reg;
      pins_meta_reg <= i_port_pins;
      pins_sync_reg <= pins_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // counter and register state
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pc_reg <= pcs_pkg::PC_RESET; // RQ4 RQ1
      status_reg <= pcs_pkg::STATUS_RESET;
      port_reg <= pcs_pkg::PORT_RESET;
      rdata_reg <= 8'h00;
    end else begin
      pc_reg <= pc_next;
      status_reg <= status_next;
      port_reg <= port_next;
      rdata_reg <= rdata_next;
    end
  end

  // sequencing control
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg <= 3'h0;
      ready_reg <= 1'b1;
      flush_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
      flush_reg <= flush_next;
    end
  end

  // outputs straight from flops
  assign o_fetch_addr = pc_reg;
  assign o_ready = ready_reg;
  assign o_flush = flush_reg;
  assign o_fr_rdata = rdata_reg;
  assign o_status = status_reg;
  assign o_port_out = port_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  wire logic seq_plain;
  assign seq_plain = accept && (i_req.op == pcs_pkg::OP_NEXT);

  // interrupt vector and its cost
  property p_int_vector;
    @(posedge i_clk) disable iff (!i_resetn)
    irq_take |=> (pc_reg == pcs_pkg::PC_INT) && o_flush && !o_ready ##1 !o_ready ##1 o_ready;
  endproperty
  a_int_vector: assert property (p_int_vector) else $error("interrupt vector wrong"); // RQ5

  // plain advance wraps at the top
  property p_seq_inc;
    @(posedge i_clk) disable iff (!i_resetn)
    seq_plain |=> (pc_reg == $past(pc_reg) + pcs_pkg::PC_ONE) && !o_flush;
  endproperty
  a_seq_inc: assert property (p_seq_inc) else $error("counter did not advance by one"); // RQ3

  // compatible mode plain instruction takes four clocks
  property p_seq_compat;
    @(posedge i_clk) disable iff (!i_resetn)
    seq_plain && !turbo_sync_reg |=> !o_ready [*3] ##1 o_ready;
  endproperty
  a_seq_compat: assert property (p_seq_compat) else $error("instruction cycle length wrong"); // RQ3

  // taken skip adds two and cancels the follower
  property p_skip;
    @(posedge i_clk) disable iff (!i_resetn)
    skip_true |=> (pc_reg == $past(pc_reg) + pcs_pkg::PC_TWO) && o_flush;
  endproperty
  a_skip: assert property (p_skip) else $error("skip did not add two"); // RQ6

  // taken skip in turbo costs two clocks
  property p_skip_cost;
    @(posedge i_clk) disable iff (!i_resetn)
    skip_true && turbo_sync_reg |=> !o_ready ##1 o_ready;
  endproperty
  a_skip_cost: assert property (p_skip_cost) else $error("skip cost wrong"); // RQ7

  // jump target from page bits and opcode field
  property p_jump;
    @(posedge i_clk) disable iff (!i_resetn)
    is_jump |=> (pc_reg[8:0] == $past(i_req.jaddr)) &&
                (pc_reg[10:9] == $past(status_reg[6:5]));
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong"); // RQ8

  // turbo jump costs three clocks
  property p_jump_cost;
    @(posedge i_clk) disable iff (!i_resetn)
    is_jump && turbo_sync_reg |=> !o_ready [*2] ##1 o_ready;
  endproperty
  a_jump_cost: assert property (p_jump_cost) else $error("jump cost wrong"); // RQ11

  // page load keeps the low status bits and costs one clock
  property p_page;
    @(posedge i_clk) disable iff (!i_resetn)
    is_page |=> (status_reg[7:5] == $past(i_req.page)) &&
               (status_reg[4:0] == $past(status_reg[4:0])) && o_ready;
  endproperty
  a_page: assert property (p_page) else $error("page load wrong"); // RQ10

  // low byte write keeps the upper bits
  property p_pcw;
    @(posedge i_clk) disable iff (!i_resetn)
    pc_write |=> pc_reg[10:8] == $past(pc_plus1[10:8]);
  endproperty
  a_pcw: assert property (p_pcw) else $error("upper counter bits changed"); // RQ12

  // low byte jump in compatible mode costs four clocks
  property p_pcw_cost;
    @(posedge i_clk) disable iff (!i_resetn)
    pc_write && !turbo_sync_reg |=> o_flush ##0 !o_ready [*3] ##1 o_ready;
  endproperty
  a_pcw_cost: assert property (p_pcw_cost) else $error("low byte jump cost wrong"); // RQ13

  // set bit rewrites the whole status byte
  property p_rmw;
    @(posedge i_clk) disable iff (!i_resetn)
    fr_writes && sel_st && (i_req.fn == pcs_pkg::FR_SETB) |=>
      status_reg == ($past(status_reg) | $past(bit_mask));
  endproperty
  a_rmw: assert property (p_rmw) else $error("bit set lost other bits"); // RQ14

  // port read returns the pins, not the register
  property p_port_read;
    @(posedge i_clk) disable iff (!i_resetn)
    accept && (i_req.op == pcs_pkg::OP_FILE) && sel_port && (i_req.fn == pcs_pkg::FR_READ)
      |=> o_fr_rdata == $past(pins_sync_reg);
  endproperty
  a_port_read: assert property (p_port_read) else $error("port read not from pins"); // RQ15

  // main scenarios
  c_skip: cover property (@(posedge i_clk) disable iff (!i_resetn) skip_true);
  c_jump_turbo: cover property (@(posedge i_clk) disable iff (!i_resetn)
    is_jump && turbo_sync_reg);
  c_pcw: cover property (@(posedge i_clk) disable iff (!i_resetn) pc_write);
  c_irq: cover property (@(posedge i_clk) disable iff (!i_resetn) irq_take);

endmodule : pcs_sequencer

// ===== pkg/pcs_pkg.sv
// constants, encodings and carriers for the program counter sequencer
// assumes one core clock at 10 MHz; cycle costs are counted in core clocks
package pcs_pkg;

  // ----------------------------------------------------------------
  // counter geometry
  // ----------------------------------------------------------------
  localparam int PC_W = 11; // 2,048-word variant; 12 for the 4,096-word one
  localparam int JADDR_W = 9;
  localparam logic [10:0] PC_RESET = 11'h7ff; // highest program address
  localparam logic [10:0] PC_INT = 11'h000; // service routine base
  localparam logic [10:0] PC_ONE = 11'h001;
  localparam logic [10:0] PC_TWO = 11'h002;

  // ----------------------------------------------------------------
  // file register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PC_LOW = 8'h02;
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_PORT = 8'h05;
  localparam int PAGE_LSB = 5;
  localparam int PAGE_MSB = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'h00;

  // ----------------------------------------------------------------
  // cycle costs in core clocks
  // ----------------------------------------------------------------
  localparam logic [2:0] COST_SEQ_TURBO = 3'h1;
  localparam logic [2:0] COST_SEQ_COMPAT = 3'h4;
  localparam logic [2:0] COST_SKIP_EXTRA = 3'h1;
  localparam logic [2:0] COST_JMP_TURBO = 3'h3;
  localparam logic [2:0] COST_JMP_COMPAT = 3'h2;
  localparam logic [2:0] COST_PCW_TURBO = 3'h3;
  localparam logic [2:0] COST_PCW_COMPAT = 3'h4;
  localparam logic [2:0] COST_PAGE = 3'h1;
  localparam logic [2:0] COST_INT = 3'h3;

  // ----------------------------------------------------------------
  // decoder request carrier
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NEXT, OP_SKIP, OP_JUMP, OP_PAGE, OP_FILE
  } pcs_op_type;

  typedef enum logic [2:0] {
    FR_READ, FR_MOV, FR_ADD, FR_SETB, FR_CLRB, FR_DEC
  } pcs_fn_type;

  typedef struct packed {
    pcs_op_type op;
    pcs_fn_type fn;
    logic [7:0] fr_addr;
    logic [2:0] bit_sel;
    logic [7:0] operand;
    logic [8:0] jaddr;
    logic [2:0] page;
  } pcs_req_type;

endpackage : pcs_pkg

// ===== bench/pcs_decoder_model.sv
// decoder stage model that faces the sequencer request port
// assumes requests change at the falling edge of the core clock
module pcs_decoder_model (
  // clock and handshake
  input wire logic i_clk,
  input wire logic i_ready,
  input wire logic i_irq,
  // request to the sequencer
  output logic o_req_valid,
  output pcs_pkg::pcs_req_type o_req
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_req_valid = 1'b0;
    o_req = '1;
  end

  // hold request until the taking edge, then release with inverted data
  task automatic send(input pcs_pkg::pcs_req_type r);
    @(negedge i_clk);
    o_req_valid = 1'b1;
    o_req = r;
    while (!(i_ready === 1'b1 && i_irq === 1'b0)) @(negedge i_clk);
    @(posedge i_clk);
    fork
      begin
        @(negedge i_clk);
        o_req_valid = 1'b0;
        o_req = ~r;
      end
    join_none
  endtask : send
endmodule : pcs_decoder_model

// ===== bench/test_program_counter_sequencer.sv
// self-checking bench for the program counter sequencer
// assumes pcs_pkg and pcs_sequencer are compiled first
module test_program_counter_sequencer;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic i_clk, i_resetn, i_turbo, i_irq, req_valid, o_ready, o_flush;
  pcs_pkg::pcs_req_type req;
  logic [7:0] i_port_pins, o_fr_rdata, o_status, o_port_out;
  logic [pcs_pkg::PC_W-1:0] o_fetch_addr;
  int fails = 0;
  int checks_done = 0;

  pcs_sequencer DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_turbo(i_turbo), .i_irq(i_irq),
    .i_req_valid(req_valid), .i_req(req), .i_port_pins(i_port_pins),
    .o_fetch_addr(o_fetch_addr), .o_ready(o_ready), .o_flush(o_flush),
    .o_fr_rdata(o_fr_rdata), .o_status(o_status), .o_port_out(o_port_out));

  pcs_decoder_model decoder (.i_clk(i_clk), .i_ready(o_ready), .i_irq(i_irq),
    .o_req_valid(req_valid), .o_req(req));

  // 10 MHz core clock
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // ----------------------------------------------------------------
  // compare, verdict and operation tasks
  // ----------------------------------------------------------------
  task automatic chk_pc(input logic [10:0] got, input logic [10:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk_pc

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_cost(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      fails++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk_cost

  task automatic test_done;
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // after a taking edge: check counter, flush pulse and clocks until ready
  task automatic settle(input int cost, input logic [10:0] pc, input logic fl);
    int k;
    logic f;
    k = 1;
    @(negedge i_clk);
    i_irq = 1'b0;
    f = o_flush;
    chk_pc(o_fetch_addr, pc);
    while (o_ready !== 1'b1 && k < 20) begin
      @(negedge i_clk);
      k++;
    end
    chk_cost(k, cost);
    if (fl !== 1'bx) chk_byte({7'h00, f}, {7'h00, fl});
  endtask : settle

  // one decoder request; d feeds operand, jump field, bit and page select
  task automatic run(input pcs_pkg::pcs_op_type op, input pcs_pkg::pcs_fn_type fn,
                     input logic [7:0] a, input logic [8:0] d, input int cost,
                     input logic [10:0] pc, input logic fl);
    decoder.send('{op, fn, a, d[2:0], d[7:0], d, d[2:0]});
    settle(cost, pc, fl);
  endtask : run

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    i_resetn = 1'b0;
    i_turbo = 1'b1;
    i_irq = 1'b0;
    i_port_pins = 8'h0f;
    repeat (8) @(negedge i_clk);
    chk_pc(o_fetch_addr, 11'h7ff);
    chk_byte(o_status, 8'h00);
    i_resetn = 1'b1;
    repeat (3) @(negedge i_clk);
    // turbo mode: wrap, page load, absolute and low-byte jumps
    run(pcs_pkg::OP_NEXT, pcs_pkg::FR_READ, 8'h00, 9'h000, 1, 11'h000, 1'b0);
    run(pcs_pkg::OP_FILE, pcs_pkg::FR_MOV, pcs_pkg::ADDR_STATUS, 9'h01f, 1, 11'h001, 1'b0);
    run(pcs_pkg::OP_PAGE, pcs_pkg::FR_READ, 8'h00, 9'h003, 1, 11'h002, 1'b0);
    chk_byte(o_status, 8'h7f);
    run(pcs_pkg::OP_JUMP, pcs_pkg::FR_READ, 8'h00, 9'h1e0, 3, 11'h7e0, 1'b1);
    run(pcs_pkg::OP_FILE, pcs_pkg::FR_READ, pcs_pkg::ADDR_PC_LOW, 9'h000, 1, 11'h7e1, 1'b0);
    chk_byte(o_fr_rdata, 8'he1);
    run(pcs_pkg::OP_FILE, pcs_pkg::FR_MOV, pcs_pkg::ADDR_PC_LOW, 9'h040, 3, 11'h740, 1'b1);
    run(pcs_pkg::OP_FILE, pcs_pkg::FR_ADD, pcs_pkg::ADDR_PC_LOW, 9'h004, 3, 11'h745, 1'b1);
    // skips on status bits, then read-modify-write ops
    run(pcs_pkg::OP_SKIP, pcs_pkg::FR_READ, pcs_pkg::ADDR_STATUS, 9'h000, 2, 11'h747, 1'b1);
    run(pcs_pkg::OP_SKIP, pcs_pkg::FR_READ, pcs_pkg::ADDR_STATUS, 9'h007, 1, 11'h748, 1'b0);
    run(pcs_pkg::OP_FILE, pcs_pkg::FR_CLRB, pcs_pkg::ADDR_STATUS, 9'h000, 1, 11'h749, 1'b0);
    chk_byte(o_status, 8'h7e);
    run(pcs_pkg::OP_FILE, pcs_pkg::FR_DEC, pcs_pkg::ADDR_STATUS, 9'h000, 1, 11'h74a, 1'b0);
    chk_byte(o_status, 8'h7d);
    run(pcs_pkg::OP_FILE, pcs_pkg::FR_SETB, pcs_pkg::ADDR_STATUS, 9'h001, 1, 11'h74b, 1'b0);
    chk_byte(o_status, 8'h7f);
    run(pcs_pkg::OP_FILE, pcs_pkg::FR_SETB, pcs_pkg::ADDR_PORT, 9'h007, 1, 11'h74c, 1'b0);
    chk_byte(o_port_out, 8'h8f);
    i_port_pins = 8'h3c;
    run(pcs_pkg::OP_NEXT, pcs_pkg::FR_READ, 8'h00, 9'h000, 1, 11'h74d, 1'b0);
    run(pcs_pkg::OP_FILE, pcs_pkg::FR_READ, pcs_pkg::ADDR_PORT, 9'h000, 1, 11'h74e, 1'b0);
    chk_byte(o_fr_rdata, 8'h3c);
    chk_byte(o_port_out, 8'h8f);
    run(pcs_pkg::OP_FILE, pcs_pkg::FR_READ, 8'h10, 9'h000, 1, 11'h74f, 1'b0);
    chk_byte(o_fr_rdata, 8'h00);
    // interrupt taken from idle
    @(negedge i_clk);
    i_irq = 1'b1;
    @(posedge i_clk);
    settle(3, 11'h000, 1'b1);
    // compatible mode costs
    i_turbo = 1'b0;
    repeat (3) @(negedge i_clk);
    run(pcs_pkg::OP_NEXT, pcs_pkg::FR_READ, 8'h00, 9'h000, 4, 11'h001, 1'b0);
    run(pcs_pkg::OP_JUMP, pcs_pkg::FR_READ, 8'h00, 9'h1e0, 2, 11'h7e0, 1'b1);
    run(pcs_pkg::OP_FILE, pcs_pkg::FR_MOV, pcs_pkg::ADDR_PC_LOW, 9'h010, 4, 11'h710, 1'b1);
    run(pcs_pkg::OP_SKIP, pcs_pkg::FR_READ, pcs_pkg::ADDR_STATUS, 9'h000, 5, 11'h712, 1'b1);
    test_done;
  end

  // watchdog well beyond the fewer than a hundred cycles the sequence needs
  initial begin
    #(3000 * 100);
    fails++;
    test_done;
  end
endmodule : test_program_counter_sequencer
